// file: logic/swt_sleep_wake_timer_control.sv
// sleep/wake power-saving sequencer with its timer registers
`timescale 1ns/1ps
`default_nettype none
module swt_sleep_wake_timer_control
  import swt_pkg::*;
#(
  parameter bit          IS_RECEIVER   = 1'b0,
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       linkUp,
  input  wire logic [3:0] digitalInputs,
  input  wire logic       txPinWake,
  output logic            powerDown,
  output logic            linkSearch,
  output logic            irqOut
);
  // ***********************************************************
  // effective settings of this unit
  // ***********************************************************
  swt_core_type  s, next_s;
  logic          tick;
  logic          expired;
  logic          load;
  logic [15:0]   loadValue;
  logic          pdBit;
  logic [7:0]    effWake;
  logic [7:0]    effExt;
  logic [15:0]   effSleep;
  logic [3:0]    pinNow;
  logic          pinChange;
  swt_phase_type sleepTarget;

  always_comb
  begin
    pdBit    = IS_RECEIVER ? s.cfg.rxModeReg[RX_PD_BIT] : s.cfg.txModeReg[TX_PD_BIT];
    effWake  = IS_RECEIVER ? s.cfg.rxWakeCount : s.cfg.txWakeCount;
    effExt   = IS_RECEIVER ? s.cfg.rxWakeExtension : s.cfg.txWakeExtension;
    effSleep = IS_RECEIVER ? s.cfg.rxSleepCount : s.cfg.txSleepCount;
    pinNow   = IS_RECEIVER ? digitalInputs : {3'b000, txPinWake};
    // receiver: each input gated by its enable, timer bit overrides
    if (IS_RECEIVER)
      pinChange = |((pinNow ^ s.pinPrev) & s.cfg.rxWakeSources[3:0])
                  && !s.cfg.rxWakeSources[RX_TIMER_BIT];
    else
      pinChange = (pinNow[0] ^ s.pinPrev[0]) && s.cfg.txModeReg[TX_PIN_WAKE_BIT];
    // configured sleep mode after any power-down entry
    if (IS_RECEIVER)
      sleepTarget = s.cfg.rxWakeSources[RX_TIMER_BIT] ? PH_SLEEP_TIMER : PH_SLEEP_PIN;
    else
      sleepTarget = s.cfg.txModeReg[TX_PIN_WAKE_BIT] ? PH_SLEEP_PIN : PH_SLEEP_TIMER;
  end

  // ***********************************************************
  // phase sequencer and register port
  // ***********************************************************
  always_comb
  begin
    next_s = s;
    load = 1'b0;
    loadValue = 16'h0000;
    next_s.pinPrev = pinNow;
    case (s.phase)
      PH_ACTIVE:
      begin
        if (linkUp)
          next_s.phase = PH_LINKED;
        else if (pdBit && (effWake != 8'h00))
        begin
          next_s.phase = sleepTarget;
          load = 1'b1;
          loadValue = effSleep;
        end
      end
      PH_WAKE:
      begin
        // the sleep timer is checked before any relink
        if (expired && (effWake != 8'h00))
        begin
          next_s.phase = sleepTarget;
          load = 1'b1;
          loadValue = effSleep;
        end
        else if (linkUp && !pdBit)
          next_s.phase = PH_LINKED;
      end
      PH_LINKED:
      begin
        if (!linkUp)
        begin
          // zero wake count disables automatic power down
          next_s.phase = (effWake != 8'h00) ? PH_SEARCH : PH_ACTIVE;
          load = 1'b1;
          loadValue = effSleep;
        end
        else if (pdBit && (effWake != 8'h00))
        begin
          next_s.phase = sleepTarget;
          load = 1'b1;
          loadValue = effSleep;
        end
        // linked with the bit cleared: stay here
      end
      PH_SEARCH:
      begin
        if (linkUp)
          next_s.phase = PH_LINKED;
        else if (expired && (effWake != 8'h00))
        begin
          next_s.phase = sleepTarget;
          load = 1'b1;
          loadValue = effSleep;
        end
        // wake count zeroed while searching: automatic power down is off
        else if (expired)
          next_s.phase = PH_ACTIVE;
      end
      PH_SLEEP_TIMER:
      begin
        if (expired)
        begin
          next_s.phase = PH_WAKE;
          load = 1'b1;
          loadValue = {8'h00, effWake};
        end
        else if (pinChange)
        begin
          next_s.phase = PH_WAKE;
          load = 1'b1;
          loadValue = swt_ext_time(effWake, effExt);
        end
      end
      PH_SLEEP_PIN:
      begin
        if (pinChange)
        begin
          next_s.phase = PH_WAKE;
          load = 1'b1;
          loadValue = swt_ext_time(effWake, effExt);
        end
      end
      default:
        next_s.phase = PH_ACTIVE;
    endcase

    if (regWrite)
    begin
      case (regAddr)
        RX_SLEEP_LOW_OFS:  next_s.cfg.rxSleepCount[7:0]  = regWrData;
        RX_SLEEP_HIGH_OFS: next_s.cfg.rxSleepCount[15:8] = regWrData;
        RX_WAKE_OFS:       next_s.cfg.rxWakeCount        = regWrData;
        RX_EXT_OFS:        next_s.cfg.rxWakeExtension    = regWrData;
        TX_EXT_OFS:        next_s.cfg.txWakeExtension    = regWrData;
        TX_SLEEP_LOW_OFS:  next_s.cfg.txSleepCount[7:0]  = regWrData;
        TX_SLEEP_HIGH_OFS: next_s.cfg.txSleepCount[15:8] = regWrData;
        TX_WAKE_OFS:       next_s.cfg.txWakeCount        = regWrData;
        RX_WAKE_SRC_OFS:   next_s.cfg.rxWakeSources      = {3'b000, regWrData[4:0]};
        TX_MODE_OFS:       next_s.cfg.txModeReg          = regWrData;
        RX_MODE_OFS:       next_s.cfg.rxModeReg          = regWrData;
        INT_CONFIG_OFS:    next_s.cfg.intConfig          = regWrData;
        default:           next_s.cfg = s.cfg;
      endcase
    end

    if (regRead)
    begin
      case (regAddr)
        RX_SLEEP_LOW_OFS:  next_s.rdData = s.cfg.rxSleepCount[7:0];
        RX_SLEEP_HIGH_OFS: next_s.rdData = s.cfg.rxSleepCount[15:8];
        RX_WAKE_OFS:       next_s.rdData = s.cfg.rxWakeCount;
        RX_EXT_OFS:        next_s.rdData = s.cfg.rxWakeExtension;
        TX_EXT_OFS:        next_s.rdData = s.cfg.txWakeExtension;
        TX_SLEEP_LOW_OFS:  next_s.rdData = s.cfg.txSleepCount[7:0];
        TX_SLEEP_HIGH_OFS: next_s.rdData = s.cfg.txSleepCount[15:8];
        TX_WAKE_OFS:       next_s.rdData = s.cfg.txWakeCount;
        RX_WAKE_SRC_OFS:   next_s.rdData = s.cfg.rxWakeSources;
        TX_MODE_OFS:       next_s.rdData = s.cfg.txModeReg;
        RX_MODE_OFS:       next_s.rdData = s.cfg.rxModeReg;
        INT_CONFIG_OFS:    next_s.rdData = s.cfg.intConfig;
        // no sticky flag: the bit is the live awake state
        INT_STATUS_OFS:    next_s.rdData = {6'b000000, !swt_is_sleep(s.phase), 1'b0};
        default:           next_s.rdData = 8'h00;
      endcase
    end

    next_s.powerDown  = swt_is_sleep(s.phase);
    next_s.linkSearch = (s.phase == PH_WAKE) || (s.phase == PH_SEARCH);
    // enabled: active level while awake, idle level while asleep
    if (s.cfg.intConfig[INT_WAKE_BIT] && !swt_is_sleep(s.phase))
      next_s.irqOut = s.cfg.intConfig[INT_POL_BIT];
    else
      next_s.irqOut = !s.cfg.intConfig[INT_POL_BIT];
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.cfg <= '0;
      s.irqOut <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ***********************************************************
  // timers of this unit only, no peer synchronisation
  // ***********************************************************
  swt_tick_prescaler #(
    .TICK_CYCLES_P (TICK_CYCLES_P)
  ) u_prescaler (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .restart  (load),
    .tick     (tick)
  );

  swt_interval_counter u_interval (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .load      (load),
    .loadValue (loadValue),
    .tick      (tick),
    .expired   (expired)
  );

  assign regRdData  = s.rdData;
  assign powerDown  = s.powerDown;
  assign linkSearch = s.linkSearch;
  assign irqOut     = s.irqOut;

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_sleep_needs_wake: assert property (
    !swt_is_sleep(s.phase) ##1 swt_is_sleep(s.phase) |-> $past(effWake) != 8'h00)
    else $error("power down entered with zero wake count");
  a_zero_wake_stays: assert property (
    s.phase == PH_WAKE && effWake == 8'h00 |=> !swt_is_sleep(s.phase))
    else $error("slept with zero wake count");
  a_timer_beats_link: assert property (
    s.phase == PH_WAKE && expired && effWake != 8'h00 && linkUp |=> swt_is_sleep(s.phase))
    else $error("relink won over sleep timer");
  a_pd_blocks_link: assert property (
    s.phase == PH_WAKE && !expired && linkUp && pdBit |=> s.phase == PH_WAKE)
    else $error("linked with power-down bit set");
  a_pin_wakes_unit: assert property (
    s.phase == PH_SLEEP_PIN && pinChange |=> s.phase == PH_WAKE ##1 linkSearch)
    else $error("pin change did not wake the unit");
  a_search_ends_sleep: assert property (
    s.phase == PH_SEARCH && expired && !linkUp && effWake != 8'h00
      |=> s.phase == sleepTarget ##1 powerDown)
    else $error("search end did not enter sleep");
  a_timer_wake_cycle: assert property (
    s.phase == PH_SLEEP_TIMER && expired |=> s.phase == PH_WAKE)
    else $error("sleep timer expiry did not wake");
  a_irq_tracks_sleep: assert property (
    s.cfg.intConfig[INT_WAKE_BIT] |=> irqOut == ($past(swt_is_sleep(s.phase))
      ^ $past(s.cfg.intConfig[INT_POL_BIT])))
    else $error("interrupt pin does not follow sleep state");
  a_status_follows: assert property (
    regRead && regAddr == INT_STATUS_OFS
      |=> regRdData[INT_WAKE_BIT] == !swt_is_sleep($past(s.phase)))
    else $error("wake status does not follow sleep state");

  c_timer_cycle: cover property (s.phase == PH_SLEEP_TIMER ##1 s.phase == PH_WAKE);
  c_relink: cover property (s.phase == PH_WAKE ##1 s.phase == PH_LINKED);
  c_pin_wake: cover property (s.phase == PH_SLEEP_PIN ##1 s.phase == PH_WAKE);
  c_search_sleep: cover property (s.phase == PH_SEARCH ##1 swt_is_sleep(s.phase));
endmodule : swt_sleep_wake_timer_control
`default_nettype wire

// file: logic/swt_pkg.sv
// constants, register map and carrier types of the sleep/wake timer control
`default_nettype none
package swt_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned TICK_PERIOD_NS = 10_000_000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [7:0] RX_SLEEP_LOW_OFS  = 8'h46;
  localparam logic [7:0] RX_SLEEP_HIGH_OFS = 8'h47;
  localparam logic [7:0] RX_WAKE_OFS       = 8'h48;
  localparam logic [7:0] RX_EXT_OFS        = 8'h4C;
  localparam logic [7:0] TX_EXT_OFS        = 8'h4D;
  localparam logic [7:0] TX_SLEEP_LOW_OFS  = 8'h57;
  localparam logic [7:0] TX_SLEEP_HIGH_OFS = 8'h58;
  localparam logic [7:0] TX_WAKE_OFS       = 8'h59;
  localparam logic [7:0] RX_WAKE_SRC_OFS   = 8'h45;
  localparam logic [7:0] TX_MODE_OFS       = 8'h20;
  localparam logic [7:0] RX_MODE_OFS       = 8'h21;
  localparam logic [7:0] INT_STATUS_OFS    = 8'h22;
  localparam logic [7:0] INT_CONFIG_OFS    = 8'h23;

  localparam int unsigned RX_PD_BIT       = 7;
  localparam int unsigned TX_PD_BIT       = 6;
  localparam int unsigned TX_PIN_WAKE_BIT = 5;
  localparam int unsigned RX_TIMER_BIT    = 4;
  localparam int unsigned INT_WAKE_BIT    = 1;
  localparam int unsigned INT_POL_BIT     = 0;
  localparam logic [7:0]  REG_RESET       = 8'h00;

  typedef enum logic [2:0] {
    PH_ACTIVE      = 3'b000,
    PH_WAKE        = 3'b001,
    PH_LINKED      = 3'b010,
    PH_SEARCH      = 3'b011,
    PH_SLEEP_TIMER = 3'b100,
    PH_SLEEP_PIN   = 3'b101
  } swt_phase_type;

  typedef struct packed {
    logic [15:0] txSleepCount;
    logic [15:0] rxSleepCount;
    logic [7:0]  txWakeCount;
    logic [7:0]  rxWakeCount;
    logic [7:0]  txWakeExtension;
    logic [7:0]  rxWakeExtension;
    logic [7:0]  txModeReg;
    logic [7:0]  rxModeReg;
    logic [7:0]  rxWakeSources;
    logic [7:0]  intConfig;
  } swt_cfg_type;

  typedef struct packed {
    logic [15:0] count;
    logic        expired;
  } swt_cnt_state_type;

  typedef struct packed {
    swt_cfg_type   cfg;
    swt_phase_type phase;
    logic [3:0]    pinPrev;
    logic [7:0]    rdData;
    logic          irqOut;
    logic          powerDown;
    logic          linkSearch;
  } swt_core_type;

  // wake time with extension; 255*256 still fits 16 bits
  function automatic logic [15:0] swt_ext_time(input logic [7:0] cnt, input logic [7:0] ext);
    logic [16:0] prod;
    prod = {9'h000, cnt} * ({9'h000, ext} + 17'h00001);
    return prod[15:0];
  endfunction : swt_ext_time

  function automatic logic swt_is_sleep(input swt_phase_type ph);
    return (ph == PH_SLEEP_TIMER) || (ph == PH_SLEEP_PIN);
  endfunction : swt_is_sleep
endpackage : swt_pkg
`default_nettype wire

// file: logic/swt_tick_prescaler.sv
// 10 ms tick generator from the core clock
`timescale 1ns/1ps
`default_nettype none
module swt_tick_prescaler
  import swt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic restart,
  output logic      tick
);
  localparam int unsigned W = $clog2(TICK_CYCLES_P + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } swt_presc_state_type;
  swt_presc_state_type s, next_s;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    // restart aligns the first tick to a phase change
    if (restart)
      next_s.cnt = '0;
    else if (s.cnt == W'(TICK_CYCLES_P - 1))
    begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end
    else
      next_s.cnt = s.cnt + W'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;

  a_tick_single: assert property (@(posedge core_clk) disable iff (!reset_n)
    (TICK_CYCLES_P > 1) && tick |=> !tick)
    else $error("tick lasted more than one cycle");
endmodule : swt_tick_prescaler
`default_nettype wire

// file: logic/swt_interval_counter.sv
// reloadable down counter of 10 ms ticks for sleep and wake phases
`timescale 1ns/1ps
`default_nettype none
module swt_interval_counter
  import swt_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic [15:0] loadValue,
  input  wire logic        tick,
  output logic             expired
);
  swt_cnt_state_type s, next_s;

  always_comb
  begin
    next_s = s;
    if (load)
    begin
      next_s.count   = loadValue;
      next_s.expired = 1'b0;
    end
    else if (tick && !s.expired)
    begin
      // a zero count expires on the first tick
      if (s.count <= 16'h0001)
        next_s.expired = 1'b1;
      next_s.count = (s.count == 16'h0000) ? 16'h0000 : s.count - 16'h0001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign expired = s.expired;

  a_load_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
    load |=> !expired)
    else $error("expired flag survived a reload");
endmodule : swt_interval_counter
`default_nettype wire

// file: bench/swt_peer_model.sv
// paired peer unit and radio link as seen by the local unit
`timescale 1ns/1ps
`default_nettype none
module swt_peer_model
  import swt_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic localDown,
  input  wire logic localSearch,
  input  wire logic peerAwake,
  input  wire logic bitsCleared,
  output logic      linkUp
);
  // ****************************************
  // link forms only with both sides awake at once
  // ****************************************
  // peer timers run on their own, so overlap is whatever the bench makes it
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      linkUp <= 1'b0;
    else
      linkUp <= peerAwake && bitsCleared && !localDown && (linkUp || localSearch);
  end
endmodule : swt_peer_model
`default_nettype wire

// file: bench/swt_sleep_wake_timer_control_tb.sv
// self-checking bench of the sleep/wake timer control, transmitter build
`timescale 1ns/1ps
`default_nettype none
module swt_sleep_wake_timer_control_tb
  import swt_pkg::*;
;
  localparam int unsigned T = 4;
  localparam logic [7:0] OFS [8] = '{TX_SLEEP_LOW_OFS, TX_SLEEP_HIGH_OFS, TX_WAKE_OFS,
    TX_EXT_OFS, RX_SLEEP_LOW_OFS, RX_SLEEP_HIGH_OFS, RX_WAKE_OFS, RX_EXT_OFS};
  logic       core_clk;
  logic       reset_n;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regRdData;
  logic       linkUp;
  logic [3:0] digitalInputs;
  logic       txPinWake;
  logic       powerDown;
  logic       linkSearch;
  logic       irqOut;
  logic       peerAwake;
  logic       bitsCleared;
  logic [7:0] rv;
  logic [7:0] wd;
  int         error_cnt;
  int         tests_run;
  int         n;
  int         w;
  int         s;

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  swt_sleep_wake_timer_control #(.IS_RECEIVER(1'b0), .TICK_CYCLES_P(T)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .linkUp(linkUp),
    .digitalInputs(digitalInputs), .txPinWake(txPinWake), .powerDown(powerDown),
    .linkSearch(linkSearch), .irqOut(irqOut));

  swt_peer_model peer (
    .core_clk(core_clk), .reset_n(reset_n), .localDown(powerDown),
    .localSearch(linkSearch), .peerAwake(peerAwake), .bitsCleared(bitsCleared),
    .linkUp(linkUp));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic timed_out();
    error_cnt++;
    $display("mismatch at %0t: wait ran out", $time);
    end_sim();
  endtask : timed_out

  // a phase of k ticks stands k*T clocks plus a small reload overhead
  function automatic logic in_win(input int cnt, input int k);
    return (cnt >= k * T) && (cnt <= k * T + 6);
  endfunction : in_win

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge core_clk);
    regWrite  <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    d = regRdData;
  endtask : rd

  task automatic do_reset();
    @(posedge core_clk);
    reset_n       <= 1'b0;
    peerAwake     <= 1'b0;
    bitsCleared   <= 1'b0;
    txPinWake     <= 1'b0;
    digitalInputs <= 4'($urandom);
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
  endtask : do_reset

  task automatic cfg(input int wk, input int sl, input int ext, input logic [7:0] mode);
    wr(TX_WAKE_OFS, 8'(wk));
    wr(TX_SLEEP_LOW_OFS, 8'(sl));
    wr(TX_SLEEP_HIGH_OFS, 8'(sl >> 8));
    wr(TX_EXT_OFS, 8'(ext));
    wr(INT_CONFIG_OFS, 8'h02);
    wr(TX_MODE_OFS, mode);
  endtask : cfg

  task automatic wait_pd(input logic lvl, input int lim);
    int k;
    k = 0;
    while (powerDown !== lvl && k < lim)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (powerDown !== lvl)
      timed_out();
  endtask : wait_pd

  task automatic span(input logic lvl, output int cnt);
    cnt = 1;
    while (cnt < 1000)
    begin
      @(posedge core_clk);
      #1;
      if (powerDown !== lvl)
        return;
      cnt++;
    end
    timed_out();
  endtask : span

  task automatic hold(input logic lvl, input int k, output int bad);
    bad = 0;
    repeat (k)
    begin
      @(posedge core_clk);
      #1;
      if (powerDown !== lvl)
        bad++;
    end
  endtask : hold

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    reset_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    digitalInputs = 4'h0;
    txPinWake = 1'b0;
    peerAwake = 1'b0;
    bitsCleared = 1'b0;
    void'($urandom(95954));
    do_reset();
    check(irqOut, 1'b1, "idle irq level");
    for (int i = 0; i < 8; i++)
    begin
      rd(OFS[i], rv);
      check(rv, REG_RESET, "reset value");
      wd = 8'($urandom);
      wr(OFS[i], wd);
      rd(OFS[i], rv);
      check(rv, wd, "readback");
    end
    rd(8'h30, rv);
    check(rv, 8'h00, "unmapped read");
    $display("test registers done");

    do_reset();
    cfg(0, 3, 0, 8'h40);
    hold(1'b0, 40, n);
    check(16'(n), 16'h0000, "slept with zero wake count");
    $display("test zero wake done");

    // first pass is the shortest legal cycle, the rest random
    for (int i = 0; i < 3; i++)
    begin
      w = (i == 0) ? 1 : 1 + $urandom % 3;
      s = (i == 0) ? 1 : 1 + $urandom % 4;
      do_reset();
      cfg(w, s, 0, 8'h40);
      wait_pd(1'b1, 60);
      check(irqOut, 1'b1, "irq while asleep");
      rd(INT_STATUS_OFS, rv);
      check(rv[INT_WAKE_BIT], 1'b0, "status while asleep");
      wait_pd(1'b0, s * T + 20);
      check(linkSearch, 1'b1, "search on wake");
      check(irqOut, 1'b0, "irq while awake");
      span(1'b0, n);
      check(in_win(n, w), 1'b1, "wake length");
      span(1'b1, n);
      check(in_win(n, s), 1'b1, "sleep length");
      rd(INT_STATUS_OFS, rv);
      check(rv[INT_WAKE_BIT], 1'b1, "status while awake");
    end
    $display("test timer cycle done");

    do_reset();
    cfg(2, 3, 0, 8'h40);
    wait_pd(1'b1, 60);
    wait_pd(1'b0, 40);
    @(posedge core_clk);
    // local unit is already awake when the peer wakes
    peerAwake   <= 1'b1;
    bitsCleared <= 1'b1;
    wr(TX_MODE_OFS, 8'h00);
    check(linkUp, 1'b1, "link formed in overlap");
    wr(TX_WAKE_OFS, 8'h00);
    hold(1'b0, 60, n);
    check(16'(n), 16'h0000, "slept while linked");
    wr(TX_WAKE_OFS, 8'h02);
    @(posedge core_clk);
    peerAwake <= 1'b0;
    span(1'b0, n);
    check(in_win(n, 3), 1'b1, "search after loss");
    wait_pd(1'b0, 3 * T + 20);
    $display("test link done");

    do_reset();
    cfg(2, 1, 1, 8'h60);
    wait_pd(1'b1, 60);
    hold(1'b1, 30, n);
    check(16'(n), 16'h0000, "pin unit woke on timer");
    @(posedge core_clk);
    txPinWake <= 1'b1;
    wait_pd(1'b0, 10);
    span(1'b0, n);
    check(in_win(n, 4), 1'b1, "extended wake length");
    $display("test pin wake done");
    end_sim();
  end
endmodule : swt_sleep_wake_timer_control_tb
`default_nettype wire
